// ---- include/sc_consts.svh ----
// Constants for the speed command smoothing block.
// Assumes a 25 MHz core clock and a 1 ms control sample.
`ifndef SC_CONSTS_SVH
`define SC_CONSTS_SVH

// Register offsets
`define SC_ADDR_LPF       16'h010C
`define SC_ADDR_ACC       16'h0144
`define SC_ADDR_DEC       16'h0146
`define SC_ADDR_CRV       16'h0148

// Reset values
`define SC_RST_LPF        16'h0000
`define SC_RST_ACC        16'h00C8
`define SC_RST_DEC        16'h00C8
`define SC_RST_CRV        16'h0000

// Legal ranges and analog-source clamps (ms)
`define SC_TIME_MAX       16'hFFDC
`define SC_LPF_MAX        16'h03E8
`define SC_ANA_ACC_MAX    16'h4E20
`define SC_ANA_CRV_MAX    16'h2710

// Speed limit in 0.1 r/min and fixed-point fraction bits
`define SC_SPEED_LIMIT    17'h0_EA60
`define SC_FRAC           16
`define SC_ANA_SHIFT      15

// Timing: clock in kHz, sample period in us
`define SC_CLK_KHZ        25000
`define SC_SAMPLE_US      1000
`define SC_SAMPLE_CYCLES  (`SC_SAMPLE_US * `SC_CLK_KHZ / 1000)

`endif

// ---- include/sc_pkg.sv ----
// Types for the speed command smoothing block.
// Assumes nothing beyond a SystemVerilog compiler.
package sc_pkg;

  typedef enum logic [2:0]
  {
    ST_WAIT = 3'b001,
    ST_DIV  = 3'b010,
    ST_UPD  = 3'b100
  } sc_state_t;

endpackage : sc_pkg

// ---- logic/sc_sync.sv ----
// Three-stage synchroniser for a select pin.
// Assumes the pin is asynchronous to i_clk.
`timescale 1ns/1ps

module sc_sync
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_pin,
  output logic      o_level
);

  logic ff1;
  logic ff2;
  logic ff3;

  // Level is accepted once stages two and three agree
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ff1     <= 1'b0;
      ff2     <= 1'b0;
      ff3     <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      ff1 <= i_pin;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3)
        o_level <= ff3;
    end
  end

endmodule : sc_sync

// ---- logic/sc_div.sv ----
// Serial restoring divider, one quotient bit per clock.
// Assumes inputs are held only at the start pulse.
`timescale 1ns/1ps

module sc_div #(parameter int W = 40)
(
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_dividend,
  input  wire logic [W-1:0] i_divisor,
  output logic      [W-1:0] o_quot,
  output logic              o_done
);

  localparam int CW = $clog2(W + 1);

  logic [W:0]    rem;
  logic [W-1:0]  dvs;
  logic [CW-1:0] cnt;
  logic [W:0]    shifted;

  assign shifted = {rem[W-1:0], o_quot[W-1]};

  // Zero divisor yields all ones
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rem    <= '0;
      dvs    <= '0;
      cnt    <= '0;
      o_quot <= '0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        rem    <= '0;
        dvs    <= i_divisor;
        o_quot <= i_dividend;
        cnt    <= CW'(W);
      end
      else if (cnt != '0)
      begin
        if (shifted >= {1'b0, dvs})
        begin
          rem    <= shifted - {1'b0, dvs};
          o_quot <= {o_quot[W-2:0], 1'b1};
        end
        else
        begin
          rem    <= shifted;
          o_quot <= {o_quot[W-2:0], 1'b0};
        end
        cnt <= cnt - 1'b1;
        if (cnt == CW'(1))
          o_done <= 1'b1;
      end
    end
  end

endmodule : sc_div

// ---- logic/sc_smooth.sv ----
// Speed command selection, analog low-pass and S-curve smoothing.
// Assumes analog samples and parameter port are on i_clk.
`timescale 1ns/1ps
`include "sc_consts.svh"

module sc_smooth import sc_pkg::*;
#(
  parameter int          SAMPLE_CYCLES = `SC_SAMPLE_CYCLES,
  parameter logic [16:0] RATED_SPEED   = 17'h0_7530
)
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_speed_select_bit_low,
  input  wire logic        i_speed_select_bit_high,
  input  wire logic        i_control_mode_setting,
  input  wire logic [15:0] i_analog_sample,
  input  wire logic [15:0] i_max_analog_speed_scale,
  input  wire logic [16:0] i_preset_speed_1,
  input  wire logic [16:0] i_preset_speed_2,
  input  wire logic [16:0] i_preset_speed_3,
  input  wire logic        i_tracking_comp_config,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_ack,
  output logic      [16:0] o_speed_cmd,
  output logic             o_cmd_valid,
  output logic             o_track_comp_en,
  output logic             o_analog_source
);

  localparam int W = 40;

  logic [15:0]        accel_ramp_time;
  logic [15:0]        decel_ramp_time;
  logic [15:0]        curve_rounding_time;
  logic [15:0]        analog_lowpass_time_constant;
  logic               sel_lo;
  logic               sel_hi;
  logic [1:0]         sel_q;
  logic [16:0]        preset_target;
  logic               analog_src;
  logic signed [35:0] ana_prod;
  logic signed [20:0] ana_wide;
  logic [16:0]        ana_speed;
  logic [16:0]        raw_cmd;
  logic signed [W-1:0] raw_q;
  logic signed [W-1:0] lpf_y;
  logic signed [W-1:0] target_q;
  logic               lpf_on;
  logic [15:0]        accel_ramp_time_eff;
  logic [15:0]        decel_ramp_time_eff;
  logic [15:0]        tsl_eff;
  logic               bypass;
  logic               linear;
  sc_state_t          state;
  logic [31:0]        tick_cnt;
  logic               tick;
  logic [W-1:0]       acc_step;
  logic [W-1:0]       dec_step;
  logic [W-1:0]       jerk_q;
  logic [W-1:0]       lpf_q;
  logic               div_done;
  logic signed [W-1:0] vel;
  logic signed [W-1:0] acc;
  logic [15:0]        cnt;
  logic signed [W-1:0] next_vel;
  logic signed [W-1:0] next_acc;
  logic [15:0]        next_cnt;
  logic signed [W:0]  err;
  logic [W:0]         err_abs;
  logic               up;
  logic [W-1:0]       amax;
  logic [W-1:0]       acc_abs;
  logic [W-1:0]       nacc_abs;
  logic [W-1:0]       jerk;
  logic [56:0]        brake;
  logic signed [W:0]  a_des;
  logic signed [W:0]  acc_try;
  logic signed [W:0]  sum;
  logic signed [W:0]  lpf_err;
  logic [W-1:0]       lpf_abs;

  //////////////////////////////////////////////////////////////////////////
  // Parameter registers, out-of-range writes ignored

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      accel_ramp_time              <= `SC_RST_ACC;
      decel_ramp_time              <= `SC_RST_DEC;
      curve_rounding_time          <= `SC_RST_CRV;
      analog_lowpass_time_constant <= `SC_RST_LPF;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == `SC_ADDR_ACC && i_reg_wdata != 16'h0000 &&
          i_reg_wdata <= `SC_TIME_MAX)
        accel_ramp_time <= i_reg_wdata;
      if (i_reg_addr == `SC_ADDR_DEC && i_reg_wdata != 16'h0000 &&
          i_reg_wdata <= `SC_TIME_MAX)
        decel_ramp_time <= i_reg_wdata;
      if (i_reg_addr == `SC_ADDR_CRV && i_reg_wdata <= `SC_TIME_MAX)
        curve_rounding_time <= i_reg_wdata;
      if (i_reg_addr == `SC_ADDR_LPF && i_reg_wdata <= `SC_LPF_MAX)
        analog_lowpass_time_constant <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack   <= 1'b0;
    end
    else
    begin
      o_reg_ack <= i_reg_rd | i_reg_wr;
      case (i_reg_addr)
        `SC_ADDR_ACC: o_reg_rdata <= accel_ramp_time;
        `SC_ADDR_DEC: o_reg_rdata <= decel_ramp_time;
        `SC_ADDR_CRV: o_reg_rdata <= curve_rounding_time;
        `SC_ADDR_LPF: o_reg_rdata <= analog_lowpass_time_constant;
        default:      o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command source

  sc_sync u_sync_lo
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_speed_select_bit_low),
    .o_level  (sel_lo)
  );

  sc_sync u_sync_hi
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_speed_select_bit_high),
    .o_level  (sel_hi)
  );

  // Preset latched only on a select change
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sel_q         <= 2'b00;
      preset_target <= 17'h0_0000;
    end
    else
    begin
      sel_q <= {sel_hi, sel_lo};
      if ({sel_hi, sel_lo} != sel_q)
      begin
        case ({sel_hi, sel_lo})
          2'b01:   preset_target <= i_preset_speed_1;
          2'b10:   preset_target <= i_preset_speed_2;
          2'b11:   preset_target <= i_preset_speed_3;
          default: preset_target <= preset_target;
        endcase
      end
    end
  end

  // Full scale sample stands for 10 V
  assign ana_prod = 36'($signed(i_analog_sample)) *
                    $signed({20'h0_0000, i_max_analog_speed_scale}) *
                    36'sh0_0000_000A;
  assign ana_wide = 21'(ana_prod >>> `SC_ANA_SHIFT);

  always_comb
  begin
    if (ana_wide > $signed({4'h0, `SC_SPEED_LIMIT}))
      ana_speed = `SC_SPEED_LIMIT;
    else if (ana_wide < -$signed({4'h0, `SC_SPEED_LIMIT}))
      ana_speed = 17'(-$signed({4'h0, `SC_SPEED_LIMIT}));
    else
      ana_speed = ana_wide[16:0];
  end

  assign analog_src = i_control_mode_setting && {sel_hi, sel_lo} == 2'b00;
  assign raw_cmd = ({sel_hi, sel_lo} != 2'b00) ? preset_target :
                   (i_control_mode_setting ? ana_speed : 17'h0_0000);
  assign raw_q   = {{(W - 33){raw_cmd[16]}}, raw_cmd, 16'h0000};

  //////////////////////////////////////////////////////////////////////////
  // Effective times

  assign accel_ramp_time_eff = (analog_src && accel_ramp_time > `SC_ANA_ACC_MAX) ?
                    `SC_ANA_ACC_MAX : accel_ramp_time;
  assign decel_ramp_time_eff = (analog_src && decel_ramp_time > `SC_ANA_ACC_MAX) ?
                    `SC_ANA_ACC_MAX : decel_ramp_time;
  assign tsl_eff  = (analog_src && curve_rounding_time > `SC_ANA_CRV_MAX) ?
                    `SC_ANA_CRV_MAX : curve_rounding_time;
  assign bypass   = analog_src && curve_rounding_time == 16'h0000;
  assign linear   = tsl_eff <= 16'h0001;
  assign lpf_on   = analog_src && analog_lowpass_time_constant != 16'h0000;
  assign target_q = lpf_on ? lpf_y : raw_q;

  //////////////////////////////////////////////////////////////////////////
  // Sample timing and step dividers

  assign tick = tick_cnt == 32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      tick_cnt <= 32'h0000_0000;
    else if (tick)
      tick_cnt <= 32'(SAMPLE_CYCLES - 1);
    else
      tick_cnt <= tick_cnt - 32'h0000_0001;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state <= ST_WAIT;
    else
    begin
      case (state)
        ST_WAIT: state <= tick ? ST_DIV : ST_WAIT;
        ST_DIV:  state <= div_done ? ST_UPD : ST_DIV;
        ST_UPD:  state <= ST_WAIT;
        default: state <= ST_WAIT;
      endcase
    end
  end

  // Per-ms speed steps in Q16 units of 0.1 r/min
  sc_div #(.W(W)) u_div_acc
  (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_start    (tick),
    .i_dividend ({7'h00, RATED_SPEED, 16'h0000}),
    .i_divisor  ({24'h00_0000, accel_ramp_time_eff}),
    .o_quot     (acc_step),
    .o_done     (div_done)
  );

  sc_div #(.W(W)) u_div_dec
  (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_start    (tick),
    .i_dividend ({7'h00, RATED_SPEED, 16'h0000}),
    .i_divisor  ({24'h00_0000, decel_ramp_time_eff}),
    .o_quot     (dec_step),
    .o_done     ()
  );

  // Jerk spreads the accel build-up over the curve time
  sc_div #(.W(W)) u_div_jerk
  (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_start    (tick),
    .i_dividend (amax),
    .i_divisor  ({24'h00_0000, tsl_eff}),
    .o_quot     (jerk_q),
    .o_done     ()
  );

  sc_div #(.W(W)) u_div_lpf
  (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_start    (tick),
    .i_dividend (lpf_abs),
    .i_divisor  ({24'h00_0000, analog_lowpass_time_constant} +
                 40'h00_0000_0001),
    .o_quot     (lpf_q),
    .o_done     ()
  );

  assign lpf_err = 41'(raw_q) - 41'(lpf_y);
  assign lpf_abs = lpf_err[W] ? W'(-lpf_err) : W'(lpf_err);
  assign jerk    = (jerk_q == '0) ? W'(1) : jerk_q;

  //////////////////////////////////////////////////////////////////////////
  // Low-pass stage

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      lpf_y <= '0;
    else if (state == ST_UPD)
    begin
      if (!lpf_on)
        lpf_y <= raw_q;
      else if (lpf_err[W])
        lpf_y <= lpf_y - $signed(lpf_q);
      else
        lpf_y <= lpf_y + $signed(lpf_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // S-curve profile

  always_comb
  begin
    err      = 41'(target_q) - 41'(vel);
    err_abs  = err[W] ? 41'(-err) : 41'(err);
    up       = !err[W];
    amax     = (vel[W-1] == err[W]) ? acc_step : dec_step;
    acc_abs  = acc[W-1] ? W'(-acc) : W'(acc);
    brake    = 57'((56'(acc_abs) * 56'(cnt)) >> 1) + 57'(acc_abs);
    a_des    = '0;
    acc_try  = 41'(acc);
    sum      = '0;
    nacc_abs = '0;
    next_vel = vel;
    next_acc = acc;
    next_cnt = cnt;
    if (bypass)
    begin
      next_vel = target_q;
      next_acc = '0;
      next_cnt = '0;
    end
    else if (err == '0)
    begin
      next_acc = '0;
      next_cnt = '0;
    end
    else if (linear)
    begin
      nacc_abs = (41'(amax) < err_abs) ? amax : W'(err_abs);
      next_acc = up ? $signed(nacc_abs) : -$signed(nacc_abs);
      next_vel = vel + next_acc;
    end
    else
    begin
      if (57'(err_abs) > brake)
        a_des = up ? $signed(41'(amax)) : -$signed(41'(amax));
      if (41'(acc) < a_des)
      begin
        acc_try = 41'(acc) + $signed(41'(jerk));
        if (acc_try > a_des)
          acc_try = a_des;
      end
      else if (41'(acc) > a_des)
      begin
        acc_try = 41'(acc) - $signed(41'(jerk));
        if (acc_try < a_des)
          acc_try = a_des;
      end
      next_acc = W'(acc_try);
      nacc_abs = next_acc[W-1] ? W'(-next_acc) : W'(next_acc);
      if (nacc_abs > acc_abs)
        next_cnt = cnt + 16'h0001;
      else if (nacc_abs < acc_abs && cnt != 16'h0000)
        next_cnt = cnt - 16'h0001;
      sum = 41'(vel) + 41'(next_acc);
      if ((41'(target_q) - sum == '0) || ((41'(target_q) - sum) < 0) == up)
      begin
        next_vel = target_q;
        next_acc = '0;
        next_cnt = '0;
      end
      else
        next_vel = W'(sum);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      vel         <= '0;
      acc         <= '0;
      cnt         <= 16'h0000;
      o_speed_cmd <= 17'h0_0000;
      o_cmd_valid <= 1'b0;
    end
    else
    begin
      o_cmd_valid <= state == ST_UPD;
      if (state == ST_UPD)
      begin
        vel         <= next_vel;
        acc         <= next_acc;
        cnt         <= next_cnt;
        o_speed_cmd <= 17'(next_vel >>> `SC_FRAC);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_track_comp_en <= 1'b0;
      o_analog_source <= 1'b0;
    end
    else
    begin
      o_analog_source <= analog_src;
      if (curve_rounding_time == 16'h0000)
        o_track_comp_en <= 1'b0;
      else if (curve_rounding_time == 16'h0001)
        o_track_comp_en <= 1'b1;
      else
        o_track_comp_en <= i_tracking_comp_config;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_acc_clamp;
    @(posedge i_clk) disable iff (!i_resetn)
    analog_src |-> accel_ramp_time_eff <= 16'h4E20 && decel_ramp_time_eff <= 16'h4E20;
  endproperty
  a_acc_clamp: assert property (p_acc_clamp)
    else $error("Analog accel time not clamped");

  property p_crv_clamp;
    @(posedge i_clk) disable iff (!i_resetn)
    analog_src |-> tsl_eff <= 16'h2710;
  endproperty
  a_crv_clamp: assert property (p_crv_clamp)
    else $error("Analog curve time not clamped");

  property p_bypass;
    @(posedge i_clk) disable iff (!i_resetn)
    (state == ST_UPD && bypass) |=> vel == $past(target_q);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Analog bypass did not pass command");

  property p_comp;
    @(posedge i_clk) disable iff (!i_resetn)
    curve_rounding_time == 16'h0000 ##1 curve_rounding_time == 16'h0000
      |-> !o_track_comp_en;
  endproperty
  a_comp: assert property (p_comp)
    else $error("Tracking comp on with curve time zero");

  property p_zero_mode;
    @(posedge i_clk) disable iff (!i_resetn)
    ({sel_hi, sel_lo} == 2'b00 && !i_control_mode_setting) |-> raw_cmd == '0;
  endproperty
  a_zero_mode: assert property (p_zero_mode)
    else $error("Zero mode command not zero");

  property p_preset_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    ({sel_hi, sel_lo} == sel_q) |=> $stable(preset_target);
  endproperty
  a_preset_hold: assert property (p_preset_hold)
    else $error("Preset changed without select change");

  property p_acc_wr;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_reg_wr && i_reg_addr == 16'h0144 && i_reg_wdata == 16'h0000)
      |=> $stable(accel_ramp_time);
  endproperty
  a_acc_wr: assert property (p_acc_wr)
    else $error("Accel time took zero");

  property p_period;
    @(posedge i_clk) disable iff (!i_resetn)
    o_cmd_valid |=> !o_cmd_valid [*8];
  endproperty
  a_period: assert property (p_period)
    else $error("Command updated too often");

  property p_lin_step;
    @(posedge i_clk) disable iff (!i_resetn)
    (state == ST_UPD && linear && !bypass)
      |=> (acc[W-1] ? W'(-acc) : W'(acc)) <= $past(amax);
  endproperty
  a_lin_step: assert property (p_lin_step)
    else $error("Linear ramp step above limit");

endmodule : sc_smooth

// ---- tb/sc_loop_model.sv ----
// Speed loop stand-in that takes each smoothed command.
// Assumes valid is a one-cycle pulse on i_clk.
`timescale 1ns/1ps

module sc_loop_model
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cmd_valid,
  input  wire logic [16:0] i_speed_cmd,
  output logic      [16:0] o_last_cmd,
  output logic      [31:0] o_gap
);
  logic [31:0] cnt;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_last_cmd <= '0;
      o_gap      <= '0;
      cnt        <= '0;
    end
    else if (i_cmd_valid)
    begin
      o_last_cmd <= i_speed_cmd;
      o_gap      <= cnt + 1;
      cnt        <= '0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : sc_loop_model

// ---- tb/testbench.sv ----
// Self-checking bench for the speed command smoothing block.
// Assumes a shortened sample period of 64 clocks.
`timescale 1ns/1ps
`include "sc_consts.svh"

module testbench;
  localparam int SC = 64;
  logic        i_clk, i_resetn, sel_lo, sel_hi, mode, wr, rd, comp;
  logic [15:0] ana, scale, addr, wdata;
  logic [16:0] pre1, pre2, pre3;
  logic [15:0] o_reg_rdata;
  logic        o_reg_ack, o_cmd_valid, o_track_comp_en, o_analog_source;
  logic [16:0] o_speed_cmd, last_cmd;
  logic [31:0] gap;
  int          miscompares, tests_run;

  sc_smooth #(.SAMPLE_CYCLES(SC)) DUT (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_speed_select_bit_low(sel_lo), .i_speed_select_bit_high(sel_hi),
    .i_control_mode_setting(mode), .i_analog_sample(ana),
    .i_max_analog_speed_scale(scale), .i_preset_speed_1(pre1),
    .i_preset_speed_2(pre2), .i_preset_speed_3(pre3),
    .i_tracking_comp_config(comp), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
    .o_speed_cmd(o_speed_cmd), .o_cmd_valid(o_cmd_valid),
    .o_track_comp_en(o_track_comp_en), .o_analog_source(o_analog_source));

  sc_loop_model LOOP (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_cmd_valid(o_cmd_valid), .i_speed_cmd(o_speed_cmd),
    .o_last_cmd(last_cmd), .o_gap(gap));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string nm, input logic [31:0] exp,
                         input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk_val

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(posedge i_clk);
    #1;
    wr = 1'b0;
    chk_val("reg_ack", 32'h0000_0001, {31'h0, o_reg_ack});
    // Idle edge so a following call never re-raises a strobe at once
    @(posedge i_clk);
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
    addr = a;
    rd   = 1'b1;
    @(posedge i_clk);
    #1;
    rd = 1'b0;
    chk_val("reg_rdata", {16'h0, exp}, {16'h0, o_reg_rdata});
    @(posedge i_clk);
    #1;
  endtask : reg_rd

  task automatic wait_valid();
    int n;
    n = 0;
    @(posedge i_clk);
    #1;
    while (o_cmd_valid !== 1'b1 && n < 4 * SC)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_val("cmd_valid", 32'h0000_0001, {31'h0, o_cmd_valid});
  endtask : wait_valid

  // Steps per sample stay within the ramp slope, then land on target
  task automatic ramp(input logic [16:0] tgt, input int step, input int n);
    int          d;
    logic [16:0] prev;
    prev = o_speed_cmd;
    repeat (n)
    begin
      wait_valid();
      d = $signed(o_speed_cmd) - $signed(prev);
      if (d > step || d < -step)
        chk_val("ramp_step", step, d);
      prev = o_speed_cmd;
    end
    chk_val("ramp_end", {15'h0, tgt}, {15'h0, o_speed_cmd});
  endtask : ramp

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    reg_rd(`SC_ADDR_ACC, 16'h00C8);
    reg_rd(`SC_ADDR_DEC, 16'h00C8);
    reg_rd(`SC_ADDR_CRV, 16'h0000);
    reg_rd(`SC_ADDR_LPF, 16'h0000);
    reg_rd(16'h0150, 16'h0000);
    reg_wr(`SC_ADDR_ACC, 16'h0000);
    reg_rd(`SC_ADDR_ACC, 16'h00C8);
    reg_wr(`SC_ADDR_CRV, 16'hFFDD);
    reg_rd(`SC_ADDR_CRV, 16'h0000);
    reg_wr(`SC_ADDR_LPF, 16'h03E9);
    reg_rd(`SC_ADDR_LPF, 16'h0000);
    reg_wr(`SC_ADDR_DEC, 16'hFFDC);
    reg_rd(`SC_ADDR_DEC, 16'hFFDC);
  endtask : t_regs

  task automatic t_preset();
    reg_wr(`SC_ADDR_ACC, 16'h000A);
    reg_wr(`SC_ADDR_DEC, 16'h0014);
    wait_valid();
    wait_valid();
    // Loop model takes the gap one edge after valid
    @(posedge i_clk);
    #1;
    chk_val("zero_cmd", 32'h0, {15'h0, o_speed_cmd});
    chk_val("gap", SC, gap);
    sel_lo = 1'b1;
    ramp(17'h0_1770, 3000, 6);
    pre1 = 17'h0_2328;
    ramp(17'h0_1770, 0, 3);
    sel_lo = 1'b0;
    ramp(17'h0_0000, 1500, 8);
  endtask : t_preset

  task automatic t_comp();
    logic [15:0] crv [4] = '{16'h0000, 16'h0001, 16'h0005, 16'h0005};
    logic        cfg [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic        exp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 4; k++)
    begin
      comp = cfg[k];
      reg_wr(`SC_ADDR_CRV, crv[k]);
      wait_valid();
      wait_valid();
      chk_val("track_comp", {31'h0, exp[k]}, {31'h0, o_track_comp_en});
    end
    reg_wr(`SC_ADDR_CRV, 16'h0000);
  endtask : t_comp

  // Curve time 4: jerk is a quarter of the linear step per sample
  task automatic t_scurve();
    reg_wr(`SC_ADDR_CRV, 16'h0004);
    wait_valid();
    sel_lo = 1'b1;
    wait_valid();
    chk_val("s_first", 32'h0000_02EE, {15'h0, o_speed_cmd});
    ramp(17'h0_2328, 3000, 6);
    sel_lo = 1'b0;
    ramp(17'h0_0000, 1500, 10);
    reg_wr(`SC_ADDR_CRV, 16'h0000);
  endtask : t_scurve

  task automatic t_analog();
    mode = 1'b1;
    ana  = 16'h4000;
    wait_valid();
    wait_valid();
    chk_val("ana_src", 32'h1, {31'h0, o_analog_source});
    chk_val("ana_cmd", 32'h0000_3A98, {15'h0, o_speed_cmd});
    @(posedge i_clk);
    #1;
    chk_val("loop_cmd", 32'h0000_3A98, {15'h0, last_cmd});
    // Low-pass with tau 1 halves the error each sample, one sample late
    reg_wr(`SC_ADDR_LPF, 16'h0001);
    ana = 16'h2000;
    wait_valid();
    chk_val("lpf_0", 32'h0000_3A98, {15'h0, o_speed_cmd});
    wait_valid();
    chk_val("lpf_1", 32'h0000_2BF2, {15'h0, o_speed_cmd});
    wait_valid();
    chk_val("lpf_2", 32'h0000_249F, {15'h0, o_speed_cmd});
    mode = 1'b0;
    ramp(17'h0_0000, 1500, 12);
    chk_val("ana_src", 32'h0, {31'h0, o_analog_source});
  endtask : t_analog

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  initial
  begin
    #2_000_000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    {i_resetn, sel_lo, sel_hi, mode, wr, rd, comp} = '0;
    {ana, addr, wdata} = '0;
    scale = 16'h0BB8;
    pre1  = 17'h0_1770;
    pre2  = 17'h0_0BB8;
    pre3  = 17'h1_F448;
    miscompares = 0;
    tests_run   = 0;
    repeat (20) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    @(posedge i_clk);
    #1;
    t_regs();
    t_preset();
    t_comp();
    t_scurve();
    t_analog();
    give_verdict();
  end
endmodule : testbench
